// >>> clock_fanout_output_control.sv
// Output control of a zero-delay differential clock fan-out driver
`timescale 1ns/100ps
`default_nettype none
module clock_fanout_output_control (
   input  wire logic                                clk,
   input  wire logic                                rst,
   input  wire logic [1:0]                          ref_clk_in,
   input  wire logic                                source_select,
   input  wire logic                                loop_bypass,
   input  wire logic                                edge_polarity_select,
   input  wire logic                                power_down_n,
   input  wire logic                                stop_style_select,
   input  wire clock_fanout_pkg::bank_ctrl_t        bank_ctrl [clock_fanout_pkg::NUM_BANKS],
   input  wire logic [1:0]                          feedback_function_select,
   input  wire logic [1:0]                          feedback_divider_select_hi,
   input  wire logic [1:0]                          feedback_divider_select_lo,
   output var  clock_fanout_pkg::diff_out_t         bank_clock_out [clock_fanout_pkg::NUM_BANKS],
   output var  clock_fanout_pkg::diff_out_t         feedback_clock_out,
   output logic [3:0]                               feedback_divide_ratio
);
   import clock_fanout_pkg::*;

   localparam int SYNC_W   = 2 + 5 + 3 * NUM_BANKS + 2 + 4;
   // Bank controls sit just above the feedback select and the two straps
   localparam int BANK_LSB = 2 + 4;

   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [1:0]        ref_s;
   logic              src_s;
   logic              bypass_s;
   logic              pol_s;
   logic              pd_n_s;
   logic              style_s;
   logic [1:0]        fb_func_s;
   logic [1:0]        ds_hi_s;
   logic [1:0]        ds_lo_s;
   logic [1:0]        func_s [NUM_CHANNELS];
   logic              stop_n_s [NUM_CHANNELS];
   logic              sel_ref;
   logic              ref_prev;
   logic              ref_edge;
   logic              osc;
   logic              base;
   logic              base_prev;
   logic              base_rise;
   logic              stop_lvl;
   logic [1:0]        div_cnt [NUM_CHANNELS];
   logic              next_q [NUM_CHANNELS];
   logic              raw_prev [NUM_CHANNELS];
   logic              stopped [NUM_CHANNELS];
   diff_out_t         chan_out [NUM_CHANNELS];

   // Every pin passes two flops; the first stage feeds only the second
   always_comb begin
      // Bank field left zero here and filled in below, so the single bits
      // above it are never overwritten
      raw_in = {ref_clk_in, source_select, loop_bypass, edge_polarity_select,
                power_down_n, stop_style_select, 15'h0000,
                feedback_function_select, feedback_divider_select_hi,
                feedback_divider_select_lo};
      for (int b = 0; b < NUM_BANKS; b++) begin
         raw_in[BANK_LSB + 3*b +: 3] = bank_ctrl[b];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   // Unpack the synchronised vector into named controls
   always_comb begin
      ref_s     = sync_b[SYNC_W-1 -: 2];
      src_s     = sync_b[SYNC_W-3];
      bypass_s  = sync_b[SYNC_W-4];
      pol_s     = sync_b[SYNC_W-5];
      pd_n_s    = sync_b[SYNC_W-6];
      style_s   = sync_b[SYNC_W-7];
      fb_func_s = sync_b[5:4];
      ds_hi_s   = sync_b[3:2];
      ds_lo_s   = sync_b[1:0];
      for (int b = 0; b < NUM_BANKS; b++) begin
         func_s[b]   = sync_b[BANK_LSB + 3*b + 1 +: 2];
         stop_n_s[b] = sync_b[BANK_LSB + 3*b];
      end
      func_s[FB_CHANNEL]   = fb_func_s;
      stop_n_s[FB_CHANNEL] = 1'b0;      // Feedback only stops on power-down
   end

   // Reference selection and alignment edge
   assign sel_ref  = src_s ? ref_s[1] : ref_s[0];
   assign ref_edge = pol_s ? (sel_ref & ~ref_prev)
                           : (~sel_ref & ref_prev);
   // True output level when stopped: opposite of the polarity select
   assign stop_lvl = ~pol_s;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_prev <= 1'b0;
      end else begin
         ref_prev <= sel_ref;
      end
   end

   // Loop stand-in: toggles, and is forced high on the chosen reference
   // edge so outputs rise there; the analogue loop itself is not modelled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc <= 1'b0;
      end else if (!pd_n_s) begin
         osc <= osc;
      end else if (ref_edge) begin
         osc <= 1'b1;
      end else begin
         osc <= ~osc;
      end
   end

   // Bypass hands the reference straight through, inverted for falling edge
   assign base      = bypass_s ? ~(sel_ref ^ pol_s) : osc;
   assign base_rise = base & ~base_prev;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         base_prev <= 1'b0;
      end else if (pd_n_s) begin
         base_prev <= base;
      end
   end

   // Dividers and stop state per channel
   for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
      assign next_q[c] = channel_clock(func_s[c], div_cnt[c], base);

      // Divider counts base rising edges; frozen in power-down
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            div_cnt[c] <= DIV_CNT_RESET;
         end else if (pd_n_s && base_rise) begin
            div_cnt[c] <= div_cnt[c] + 2'h1;
         end
      end

      // Stop changes only as the clock enters the stop level, so the
      // last pulse is whole and the first after release is whole too
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            raw_prev[c] <= 1'b0;
            stopped[c]  <= 1'b0;
         end else if (pd_n_s) begin
            raw_prev[c] <= next_q[c];
            if (next_q[c] == stop_lvl && raw_prev[c] != stop_lvl) begin
               // Stop input high halts the bank
               stopped[c] <= stop_n_s[c];
            end
         end
      end

      // Output register; power-down overrides the bank stop at once
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            chan_out[c] <= '{q: 1'b0, q_n: 1'b1, oe_n: 1'b1};
         end else if (!pd_n_s) begin
            chan_out[c].q    <= stop_lvl;
            chan_out[c].q_n  <= ~stop_lvl;
            chan_out[c].oe_n <= ~style_s;
         end else if (stopped[c]) begin
            chan_out[c].q    <= stop_lvl;
            chan_out[c].q_n  <= ~stop_lvl;
            chan_out[c].oe_n <= ~style_s;
         end else begin
            chan_out[c].q    <= next_q[c];
            chan_out[c].q_n  <= ~next_q[c];
            chan_out[c].oe_n <= 1'b0;
         end
      end

      // Halted or powered-down channel holds the stop level
      a_stop_level: assert property (
         @(posedge clk) disable iff (rst)
         (!pd_n_s || stopped[c]) |=> chan_out[c].q == $past(stop_lvl)
            && chan_out[c].q_n == !$past(stop_lvl))
         else $error("stopped output not at stop level");

      // Enable follows style select while halted
      a_stop_style: assert property (
         @(posedge clk) disable iff (rst)
         (!pd_n_s || stopped[c]) |=> chan_out[c].oe_n == !$past(style_s))
         else $error("stopped output enable wrong for style");

      // Running channel drives its function clock
      a_run_clock: assert property (
         @(posedge clk) disable iff (rst)
         (pd_n_s && !stopped[c]) |=> !chan_out[c].oe_n
            && chan_out[c].q == $past(next_q[c]))
         else $error("running output does not follow its clock");

      // Stop entry happens only where the clock enters the stop level
      a_stop_edge: assert property (
         @(posedge clk) disable iff (rst)
         $rose(stopped[c]) |-> $past(next_q[c]) == $past(stop_lvl))
         else $error("stop applied off a clock boundary");

      // Divider frozen while powered down
      a_pd_freeze: assert property (
         @(posedge clk) disable iff (rst)
         !pd_n_s ##1 !pd_n_s |-> $stable(div_cnt[c]))
         else $error("divider moved during power-down");
   end

   // Drive the top-level outputs from the channel registers
   always_comb begin
      for (int b = 0; b < NUM_BANKS; b++) begin
         bank_clock_out[b] = chan_out[b];
      end
      feedback_clock_out = chan_out[FB_CHANNEL];
   end

   // Feedback divider ratio from the two straps
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         feedback_divide_ratio <= FB_RATIO_RESET;
      end else begin
         feedback_divide_ratio <= divide_ratio(ds_hi_s, ds_lo_s);
      end
   end

   // In rising-edge bypass an undivided feedback output shows the synchronised
   // reference picked by the source select one edge later; checks the path after the synchronisers
   a_ref_select: assert property (
      @(posedge clk) disable iff (rst)
      (pd_n_s && bypass_s && pol_s && func_s[FB_CHANNEL] == FUNC_ZERO)
         |=> feedback_clock_out.q == $past(ref_s[src_s]))
      else $error("wrong reference selected");

   // Bypass passes the reference through unchanged in rising mode
   a_bypass_path: assert property (
      @(posedge clk) disable iff (rst)
      (bypass_s && pol_s) |-> base == sel_ref)
      else $error("bypass does not route the reference");

   // Strap low/low gives divide by two
   a_div_ratio: assert property (
      @(posedge clk) disable iff (rst)
      (ds_hi_s == LEVEL_LOW && ds_lo_s == LEVEL_LOW)
         |=> feedback_divide_ratio == 4'h2)
      else $error("feedback divide ratio wrong");

   // Loop stand-in goes high right after the chosen reference edge
   a_edge_align: assert property (
      @(posedge clk) disable iff (rst)
      (pd_n_s && ref_edge) |=> osc)
      else $error("outputs not aligned to reference edge");

endmodule
`default_nettype wire

// >>> clock_fanout_pkg.sv
// Shared types and constants for the clock fan-out output control block
`default_nettype none
package clock_fanout_pkg;

   // Five output banks plus the feedback bank at the top index
   localparam int NUM_BANKS    = 5;
   localparam int NUM_CHANNELS = 6;
   localparam int FB_CHANNEL   = 5;

   // Values after reset
   localparam logic [1:0] DIV_CNT_RESET  = 2'h0;
   localparam logic [3:0] FB_RATIO_RESET = 4'h1;

   // Per-bank function select encoding
   typedef enum logic [1:0] {
      FUNC_DIV2   = 2'h0,
      FUNC_DIV4   = 2'h1,
      FUNC_ZERO   = 2'h2,
      FUNC_INVERT = 2'h3
   } bank_function_t;

   // Three-level static strap as seen after the level detector
   typedef enum logic [1:0] {
      LEVEL_LOW  = 2'h0,
      LEVEL_MID  = 2'h1,
      LEVEL_HIGH = 2'h2
   } three_level_t;

   // One differential output: true, complement, output enable (low drives)
   typedef struct packed {
      logic q;
      logic q_n;
      logic oe_n;
   } diff_out_t;

   // Static controls of one output bank
   typedef struct packed {
      logic [1:0] func;
      logic       stop_n;
   } bank_ctrl_t;

   // Feedback input divide ratio from the two three-level straps
   function automatic logic [3:0] divide_ratio(input logic [1:0] hi,
                                               input logic [1:0] lo);
      logic [3:0] ratio;
      ratio = 4'h1;
      case ({hi, lo})
         {LEVEL_LOW,  LEVEL_LOW}:  ratio = 4'h2;
         {LEVEL_LOW,  LEVEL_MID}:  ratio = 4'h3;
         {LEVEL_LOW,  LEVEL_HIGH}: ratio = 4'h4;
         {LEVEL_MID,  LEVEL_LOW}:  ratio = 4'h5;
         {LEVEL_MID,  LEVEL_MID}:  ratio = 4'h1;
         {LEVEL_MID,  LEVEL_HIGH}: ratio = 4'h6;
         {LEVEL_HIGH, LEVEL_LOW}:  ratio = 4'h8;
         {LEVEL_HIGH, LEVEL_MID}:  ratio = 4'hA;
         {LEVEL_HIGH, LEVEL_HIGH}: ratio = 4'hC;
         default:                  ratio = 4'h1;
      endcase
      return ratio;
   endfunction

   // Clock seen by one channel for its function select
   function automatic logic channel_clock(input logic [1:0] func,
                                          input logic [1:0] cnt,
                                          input logic       base);
      logic clk_out;
      clk_out = base;
      case (func)
         FUNC_DIV2:   clk_out = cnt[0];
         FUNC_DIV4:   clk_out = cnt[1];
         FUNC_ZERO:   clk_out = base;
         FUNC_INVERT: clk_out = ~base;
         default:     clk_out = base;
      endcase
      return clk_out;
   endfunction

endpackage
`default_nettype wire

// >>> ref_clock_source.sv
// Reference clock sources standing in for the board oscillators
`timescale 1ns/100ps
`default_nettype none
module ref_clock_source #(
   parameter int HALF0 = 40,
   parameter int HALF1 = 70
) (
   output var logic [1:0] ref_clk
);
   // Edges sit 3 ns and 7 ns off the system clock grid, so a sampling
   // flop never sees a reference edge at its own clock edge
   initial begin
      ref_clk[0] = 1'b0;
      #3;
      forever #(HALF0) ref_clk[0] = ~ref_clk[0];
   end
   // Second source at an unrelated rate, to tell the two apart
   initial begin
      ref_clk[1] = 1'b0;
      #7;
      forever #(HALF1) ref_clk[1] = ~ref_clk[1];
   end
endmodule
`default_nettype wire

// >>> clock_fanout_output_control_test.sv
// Self-checking bench for the clock fan-out output control block
`timescale 1ns/100ps
`default_nettype none
module clock_fanout_output_control_test;
   import clock_fanout_pkg::*;
   logic       clk, rst, src_sel, bypass, pol, pd_n, style;
   logic [1:0] ref_clk, fb_func, ds_hi, ds_lo;
   logic [3:0] ratio;
   bank_ctrl_t ctrl [NUM_BANKS];
   diff_out_t  bout [NUM_BANKS];
   diff_out_t  fb;
   logic [2:0] hist [2];
   int         fail_count, checks, c2, c4;
   logic       l2, l4;
   localparam logic [3:0] RATIO_TBL [9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h1,
      4'h6, 4'h8, 4'hA, 4'hC};

   ref_clock_source SRC (.ref_clk(ref_clk));
   clock_fanout_output_control DUT (
      .clk(clk), .rst(rst), .ref_clk_in(ref_clk), .source_select(src_sel),
      .loop_bypass(bypass), .edge_polarity_select(pol),
      .power_down_n(pd_n), .stop_style_select(style), .bank_ctrl(ctrl),
      .feedback_function_select(fb_func),
      .feedback_divider_select_hi(ds_hi),
      .feedback_divider_select_lo(ds_lo), .bank_clock_out(bout),
      .feedback_clock_out(fb), .feedback_divide_ratio(ratio));

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Reference history as the synchronisers see it; oldest is three deep
   always @(posedge clk) begin
      hist[0] <= {hist[0][1:0], ref_clk[0]};
      hist[1] <= {hist[1][1:0], ref_clk[1]};
   end

   function automatic diff_out_t chan(input int c);
      return (c == FB_CHANNEL) ? fb : bout[c];
   endfunction
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic check_out(input int c, input logic [2:0] exp);
      check({5'h00, chan(c)}, {5'h00, exp});
   endtask
   // Transitions of one channel's true output over n cycles
   task automatic toggles(input int c, input int n, output int cnt);
      logic last;
      cnt = 0;
      last = chan(c).q;
      repeat (n) begin
         step(1);
         if (chan(c).q !== last) cnt++;
         last = chan(c).q;
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Hang guard, well beyond the 716 cycles the tests need
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end

   initial begin
      rst = 1'b1; src_sel = 1'b0; bypass = 1'b0; pol = 1'b1; pd_n = 1'b1;
      style = 1'b1; fb_func = FUNC_ZERO; ds_hi = LEVEL_MID; ds_lo = LEVEL_MID;
      for (int b = 0; b < NUM_BANKS; b++) ctrl[b] = '{FUNC_ZERO, 1'b0};
      step(16);
      for (int c = 0; c < NUM_CHANNELS; c++) check_out(c, 3'h3);
      check({4'h0, ratio}, 8'h01);
      rst = 1'b0;
      $display("test reset done");
      // Every strap combination, low/mid/high on each
      for (int i = 0; i < 9; i++) begin
         ds_hi = 2'(i / 3);
         ds_lo = 2'(i % 3);
         step(4);
         check({4'h0, ratio}, {4'h0, RATIO_TBL[i]});
      end
      $display("test straps done");
      // Power-down in each polarity and style; nothing may move after
      for (int m = 0; m < 4; m++) begin
         {pol, style} = 2'(m);
         pd_n = 1'b0;
         step(4);
         for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < NUM_CHANNELS; c++)
               check_out(c, {~pol, pol, ~style});
            step(8);
         end
         pd_n = 1'b1;
         step(6);
      end
      $display("test power-down done");
      // Stop bank 0 while bank 1 runs, then release it
      for (int m = 0; m < 4; m++) begin
         {pol, style} = 2'(m);
         ctrl[0].stop_n = 1'b1;
         step(20);
         check_out(0, {~pol, pol, ~style});
         toggles(1, 8, c2);
         check({7'h00, c2 > 0}, 8'h01);
         check_out(0, {~pol, pol, ~style});
         ctrl[0].stop_n = 1'b0;
         step(20);
         toggles(0, 8, c2);
         check({7'h00, c2 > 0 && bout[0].oe_n === 1'b0}, 8'h01);
      end
      $display("test bank stop done");
      // Function selects through the loop stand-in
      ctrl[0].func = FUNC_DIV2;
      ctrl[1].func = FUNC_DIV4;
      ctrl[3].func = FUNC_INVERT;
      fb_func = FUNC_INVERT;
      step(8);
      c2 = 0; c4 = 0; l2 = bout[0].q; l4 = bout[1].q;
      repeat (64) begin
         step(1);
         check({7'h00, bout[3].q}, {7'h00, ~bout[2].q});
         check({7'h00, fb.q}, {7'h00, ~bout[2].q});
         check({7'h00, bout[0].q_n}, {7'h00, ~bout[0].q});
         if (bout[0].q !== l2) c2++;
         if (bout[1].q !== l4) c4++;
         l2 = bout[0].q;
         l4 = bout[1].q;
      end
      check({7'h00, c4 > 0 && c2 >= 2 * c4 - 2 && c2 <= 2 * c4 + 2},
            8'h01);
      $display("test functions done");
      // Bypass: zero-delay bank follows the chosen reference
      bypass = 1'b1;
      fb_func = FUNC_ZERO;
      for (int m = 0; m < 4; m++) begin
         {pol, src_sel} = 2'(m);
         step(6);
         repeat (60) begin
            step(1);
            check({7'h00, bout[2].q},
                  {7'h00, hist[src_sel][2] ^ ~pol});
            check({7'h00, fb.q},
                  {7'h00, hist[src_sel][2] ^ ~pol});
         end
      end
      $display("test bypass done");
      give_verdict();
   end
endmodule
`default_nettype wire
